// ===== common/pgwrd_defines.svh
// Purpose: Offsets, field positions and codes of the graphics datapath
// Assumes: Byte-wide host I/O and memory cycles
// Notes: Index values address the data-port register file
`ifndef PGWRD_DEFINES_SVH
`define PGWRD_DEFINES_SVH
`define PGWRD_INDEX_PORT 16'h03ce
`define PGWRD_DATA_PORT 16'h03cf
`define PGWRD_IDX_FILL_VALUE 4'h0
`define PGWRD_IDX_FILL_ENABLE 4'h1
`define PGWRD_IDX_CMP_VALUE 4'h2
`define PGWRD_IDX_ROTATE_OP 4'h3
`define PGWRD_IDX_READ_PLANE 4'h4
`define PGWRD_IDX_MODE_CTRL 4'h5
`define PGWRD_IDX_WINDOW_CTRL 4'h6
`define PGWRD_IDX_CMP_INCLUDE 4'h7
`define PGWRD_IDX_BIT_MASK 4'h8
`define PGWRD_RESET_BYTE 8'h00
`define PGWRD_RESET_MASK 8'hff
`define PGWRD_WIN_A0000 20'ha0000
`define PGWRD_WIN_B0000 20'hb0000
`define PGWRD_WIN_B8000 20'hb8000
`endif

// ===== common/pgwrd_pkg.sv
// Purpose: Types shared by the graphics datapath
// Assumes: Nothing beyond the defines header
// Notes: Encodings follow the mode register fields
package pgwrd_pkg;
  typedef enum logic [1:0] {
    PGWRD_WM_FILL,
    PGWRD_WM_LATCH,
    PGWRD_WM_EXPAND,
    PGWRD_WM_MASKED
  } pgwrd_wmode_t;
  typedef enum logic [1:0] {
    PGWRD_OP_PASS,
    PGWRD_OP_AND,
    PGWRD_OP_OR,
    PGWRD_OP_XOR
  } pgwrd_op_t;
  typedef enum {
    PGWRD_IDLE,
    PGWRD_MEM_READ,
    PGWRD_MEM_WRITE
  } pgwrd_state_t;
endpackage

// ===== rtl/pgwrd_datapath.sv
// Purpose: Graphics write/read datapath between host bus and four planes
// Assumes: Host strobes are synchronous one-cycle pulses on mclk
// Notes: Plane memory is external; read data arrives one cycle after ask
`include "pgwrd_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Low four index bits select data register
// - Mode 0 enabled planes take fill value
// - Mode 0 other planes take rotated host byte
// - Compare read returns ones where colours match
// - Only included planes join the comparison
// - Function select passes, ANDs, ORs, XORs latches
// - Host byte rotated right by count
// - Plane read returns selected plane byte
// - Mode bit picks plane or compare read
// - Mode 1 writes latches; reads reload latches
// - Mode 2 expands host bits per plane
// - Mode 3 fill value, rotated byte masks
// - Write mode field selects write mode
// - Bit mask keeps latch where zero
// - Window field decodes host memory range
// - Chain bit swaps address lsb, picks plane
// - Odd/even bit routes host addresses to planes
// - Shift format splits even and odd bits
// - 256-colour bit selects shift load format
module pgwrd_datapath (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Host I/O port
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  // Host memory port
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [19:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_rvalid,
  // Sequencer inputs
  input wire logic seq_chain4,
  input wire logic seq_high_bit,
  // Plane memory port
  output logic [15:0] plane_addr,
  output logic display_memory_address_lsb,
  output logic plane_rd,
  output logic [3:0] plane_we,
  output logic [31:0] plane_wdata,
  input wire logic [31:0] plane_rdata,
  // Video shift load
  input wire logic shift_load,
  input wire logic [31:0] shift_data,
  output logic [31:0] shift_out,
  output logic graphics_mode
);
  logic [3:0] index_ptr;
  logic [7:0] fill_value, fill_enable, cmp_value, rot_op, rd_plane;
  logic [7:0] mode_ctrl, window_ctrl, cmp_include, bit_mask;
  logic [31:0] latches;
  logic pend_lsb;
  pgwrd_pkg::pgwrd_state_t state;

  function automatic logic [7:0] rotr(input logic [7:0] d,
                                      input logic [2:0] n);
    logic [15:0] dd;
    dd = {d, d} >> n;
    return dd[7:0];
  endfunction

  function automatic logic [7:0] alu(input logic [7:0] d,
                                     input logic [7:0] l,
                                     input logic [1:0] op);
    logic [7:0] r;
    case (op)
      2'h1: r = d & l;
      2'h2: r = d | l;
      2'h3: r = d ^ l;
      default: r = d;
    endcase
    return r;
  endfunction

  // Byte of one plane within a 32-bit word
  function automatic logic [7:0] lane(input logic [31:0] w,
                                      input logic [1:0] p);
    return w[8*p +: 8];
  endfunction

  // Host range decode; addresses outside the range never start a cycle
  function automatic logic window_hit(input logic [1:0] w,
                                      input logic [19:0] a);
    logic h;
    case (w)
      2'h0: h = a[19:17] == 3'(`PGWRD_WIN_A0000 >> 17);
      2'h1: h = a[19:16] == 4'(`PGWRD_WIN_A0000 >> 16);
      2'h2: h = a[19:15] == 5'(`PGWRD_WIN_B0000 >> 15);
      default: h = a[19:15] == 5'(`PGWRD_WIN_B8000 >> 15);
    endcase
    return h;
  endfunction

  // Named control fields
  wire [2:0] rot_count = rot_op[2:0];
  wire [1:0] logic_op = rot_op[4:3];
  wire read_compare = mode_ctrl[3];
  wire shift_interleave = mode_ctrl[5];
  wire load_256 = mode_ctrl[6];

  // Register decode
  wire io_idx_hit = io_addr == `PGWRD_INDEX_PORT;
  wire io_dat_hit = io_addr == `PGWRD_DATA_PORT;
  logic [7:0] idx_rdata;
  always_comb begin
    case (index_ptr)
      `PGWRD_IDX_FILL_VALUE: idx_rdata = fill_value;
      `PGWRD_IDX_FILL_ENABLE: idx_rdata = fill_enable;
      `PGWRD_IDX_CMP_VALUE: idx_rdata = cmp_value;
      `PGWRD_IDX_ROTATE_OP: idx_rdata = rot_op;
      `PGWRD_IDX_READ_PLANE: idx_rdata = rd_plane;
      `PGWRD_IDX_MODE_CTRL: idx_rdata = mode_ctrl;
      `PGWRD_IDX_WINDOW_CTRL: idx_rdata = window_ctrl;
      `PGWRD_IDX_CMP_INCLUDE: idx_rdata = cmp_include;
      `PGWRD_IDX_BIT_MASK: idx_rdata = bit_mask;
      // Unused indices read zero so stray probes stay harmless
      default: idx_rdata = `PGWRD_RESET_BYTE;
    endcase
  end
  // Index port reads back with reserved bits clear
  wire [7:0] next_io_rdata =
    io_idx_hit ? {4'h0, index_ptr} : io_dat_hit ? idx_rdata : 8'h00;

  // Memory window decode
  wire [1:0] win = window_ctrl[3:2];
  wire win_hit = window_hit(win, mem_addr);
  wire [16:0] win_off =
    (win == 2'h0) ? mem_addr[16:0] : {1'b0, mem_addr[15:0]};

  // Odd/even routing
  wire chain_oe = window_ctrl[1];
  wire host_oe = mode_ctrl[4];
  wire [15:0] next_plane_addr =
    chain_oe ? {win_off[15:1], seq_high_bit} : win_off[15:0];
  wire [3:0] next_sel =
    (chain_oe | host_oe) ? (mem_addr[0] ? 4'ha : 4'h5) : 4'hf;

  // Write datapath
  pgwrd_pkg::pgwrd_wmode_t wmode;
  assign wmode = pgwrd_pkg::pgwrd_wmode_t'(mode_ctrl[1:0]);
  wire [7:0] rot = rotr(mem_wdata, rot_count);
  wire [7:0] eff_mask =
    (wmode == pgwrd_pkg::PGWRD_WM_MASKED) ? (rot & bit_mask) : bit_mask;
  // Mode 1 skips the function unit; latches go out raw
  logic [31:0] next_wdata;
  always_comb begin
    next_wdata = latches;
    for (int p = 0; p < 4; p++) begin
      logic [7:0] src;
      logic [7:0] lat;
      src = 8'h00;
      lat = latches[8*p +: 8];
      case (wmode)
        pgwrd_pkg::PGWRD_WM_FILL: begin
          src = fill_enable[p] ? {8{fill_value[p]}} : rot;
        end
        pgwrd_pkg::PGWRD_WM_EXPAND: begin
          src = {8{mem_wdata[p]}};
        end
        pgwrd_pkg::PGWRD_WM_MASKED: begin
          src = {8{fill_value[p]}};
        end
        default: begin
          src = lat;
        end
      endcase
      if (wmode != pgwrd_pkg::PGWRD_WM_LATCH) begin
        src = alu(src, lat, logic_op);
        next_wdata[8*p +: 8] = (src & eff_mask) | (lat & ~eff_mask);
      end
    end
  end

  // Read datapath; compare and plane select
  // Excluded planes leave every position matching
  logic [7:0] cmp_result;
  always_comb begin
    cmp_result = 8'hff;
    for (int p = 0; p < 4; p++) begin
      if (cmp_include[p]) begin
        cmp_result = cmp_result &
          ~(lane(plane_rdata, 2'(p)) ^ {8{cmp_value[p]}});
      end
    end
  end
  // Chained reads take plane bit 0 from host lsb; plane select bit 1 still applies
  wire [1:0] rd_idx = seq_chain4 ? {rd_plane[1], pend_lsb} : rd_plane[1:0];
  wire [7:0] plane_byte = lane(plane_rdata, rd_idx);
  wire [7:0] next_mem_rdata = read_compare ? cmp_result : plane_byte;

  // Shift register load formats
  // 256-colour load reverses the pixel pairs of each byte
  logic [31:0] next_shift;
  always_comb begin
    next_shift = shift_data;
    if (load_256) begin
      for (int b = 0; b < 4; b++) begin
        next_shift[8*b +: 8] = {shift_data[8*b +: 2], shift_data[8*b+2 +: 2],
          shift_data[8*b+4 +: 2], shift_data[8*b+6 +: 2]};
      end
    end else if (shift_interleave) begin
      for (int p = 0; p < 4; p++) begin
        for (int k = 0; k < 4; k++) begin
          next_shift[8*p+7-k] = shift_data[8*(p & 2)+7-2*k-(p & 1)];
          next_shift[8*p+3-k] = shift_data[8*((p & 2)+1)+7-2*k-(p & 1)];
        end
      end
    end
  end

  // Host I/O registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      index_ptr <= 4'h0;
      fill_value <= `PGWRD_RESET_BYTE;
      fill_enable <= `PGWRD_RESET_BYTE;
      cmp_value <= `PGWRD_RESET_BYTE;
      rot_op <= `PGWRD_RESET_BYTE;
      rd_plane <= `PGWRD_RESET_BYTE;
      mode_ctrl <= `PGWRD_RESET_BYTE;
      window_ctrl <= `PGWRD_RESET_BYTE;
      cmp_include <= `PGWRD_RESET_BYTE;
      bit_mask <= `PGWRD_RESET_MASK;
    end else if (io_wr && io_idx_hit) begin
      index_ptr <= io_wdata[3:0];
    end else if (io_wr && io_dat_hit) begin
      case (index_ptr)
        `PGWRD_IDX_FILL_VALUE: fill_value <= io_wdata;
        `PGWRD_IDX_FILL_ENABLE: fill_enable <= io_wdata;
        `PGWRD_IDX_CMP_VALUE: cmp_value <= io_wdata;
        `PGWRD_IDX_ROTATE_OP: rot_op <= io_wdata;
        `PGWRD_IDX_READ_PLANE: rd_plane <= io_wdata;
        `PGWRD_IDX_MODE_CTRL: mode_ctrl <= io_wdata;
        `PGWRD_IDX_WINDOW_CTRL: window_ctrl <= io_wdata;
        `PGWRD_IDX_CMP_INCLUDE: cmp_include <= io_wdata;
        `PGWRD_IDX_BIT_MASK: bit_mask <= io_wdata;
        default: ;
      endcase
    end
  end

  // Read data holds until the next read
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      io_rdata <= 8'h00;
      io_rvalid <= 1'b0;
    end else begin
      io_rdata <= io_rd ? next_io_rdata : io_rdata;
      io_rvalid <= io_rd;
    end
  end

  // Memory cycle sequencing; reads and writes each take two cycles
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state <= pgwrd_pkg::PGWRD_IDLE;
      plane_addr <= 16'h0000;
      display_memory_address_lsb <= 1'b0;
      plane_rd <= 1'b0;
      plane_we <= 4'h0;
      plane_wdata <= 32'h0;
      pend_lsb <= 1'b0;
      latches <= 32'h0;
      mem_rdata <= 8'h00;
      mem_rvalid <= 1'b0;
    end else begin
      plane_rd <= 1'b0;
      plane_we <= 4'h0;
      mem_rvalid <= 1'b0;
      // Requests arriving mid-read are dropped; the host must pace them
      case (state)
        pgwrd_pkg::PGWRD_IDLE: begin
          if (mem_rd && win_hit) begin
            plane_addr <= next_plane_addr;
            display_memory_address_lsb <= next_plane_addr[0];
            plane_rd <= 1'b1;
            pend_lsb <= mem_addr[0];
            state <= pgwrd_pkg::PGWRD_MEM_READ;
          end else if (mem_wr && win_hit) begin
            plane_addr <= next_plane_addr;
            display_memory_address_lsb <= next_plane_addr[0];
            plane_we <= next_sel;
            plane_wdata <= next_wdata;
            state <= pgwrd_pkg::PGWRD_MEM_WRITE;
          end
        end
        pgwrd_pkg::PGWRD_MEM_READ: begin
          latches <= plane_rdata;
          mem_rdata <= next_mem_rdata;
          mem_rvalid <= 1'b1;
          state <= pgwrd_pkg::PGWRD_IDLE;
        end
        default: begin
          state <= pgwrd_pkg::PGWRD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      shift_out <= 32'h0;
    end else begin
      shift_out <= shift_load ? next_shift : shift_out;
    end
  end

  // Mirror only; software must keep the attribute side equal
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      graphics_mode <= 1'b0;
    end else begin
      graphics_mode <= window_ctrl[0];
    end
  end
endmodule
`default_nettype wire

// ===== verif/pgwrd_plane_model.sv
// Purpose: Four-plane display memory model
// Assumes: 16 words selected by plane_addr low bits
// Notes: Read data exists only while plane_rd is high
`timescale 1ns/1ps
`default_nettype none
module pgwrd_plane_model (
  // Plane port
  input wire logic mclk,
  input wire logic [15:0] plane_addr,
  input wire logic plane_rd,
  input wire logic [3:0] plane_we,
  input wire logic [31:0] plane_wdata,
  output logic [31:0] plane_rdata
);
  logic [31:0] mem [16];
  logic [31:0] junk = 32'h5a5a5a5a;
  // Toggling filler so a late sample never sees stale data
  assign plane_rdata = plane_rd ? mem[plane_addr[3:0]] : junk;
  initial for (int i = 0; i < 16; i++) mem[i] = (i + 1) * 32'h9e3779b9;
  always @(posedge mclk) begin
    junk <= ~junk;
    for (int p = 0; p < 4; p++)
      if (plane_we[p]) mem[plane_addr[3:0]][8*p +: 8] <= plane_wdata[8*p +: 8];
  end
endmodule
`default_nettype wire

// ===== verif/pgwrd_props.sv
// Purpose: Port assertions for pgwrd_datapath
// Assumes: One clock, sync low reset
// Notes: Bound at file foot
`timescale 1ns/1ps
`default_nettype none
module pgwrd_props (
  // Watched ports
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic io_rd,
  input wire logic io_rvalid,
  input wire logic [7:0] io_rdata,
  input wire logic mem_rvalid,
  input wire logic plane_rd,
  input wire logic [3:0] plane_we,
  input wire logic [15:0] plane_addr,
  input wire logic display_memory_address_lsb
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  io_answer_a: assert property (io_rd |=> io_rvalid)
    else $error("io read unanswered");
  io_cause_a: assert property (io_rvalid |-> $past(io_rd))
    else $error("stray io answer");
  data_hold_a: assert property (!io_rvalid |-> $stable(io_rdata))
    else $error("io data moved");
  mem_answer_a: assert property (plane_rd |=> mem_rvalid)
    else $error("memory read unanswered");
  mem_cause_a: assert property (mem_rvalid |-> $past(plane_rd))
    else $error("stray memory answer");
  lsb_copy_a: assert property (
    display_memory_address_lsb == plane_addr[0]) else $error("lsb differs");
  no_clash_a: assert property (plane_rd |-> plane_we == 4'h0)
    else $error("read and write together");
  we_pulse_a: assert property (|plane_we |=> plane_we == 4'h0)
    else $error("write strobe too long");
  cover property (plane_rd);
  cover property (|plane_we);
  cover property (io_rvalid);
endmodule
bind pgwrd_datapath pgwrd_props i_pgwrd_props (.mclk, .reset_n, .io_rd,
  .io_rvalid, .io_rdata, .mem_rvalid, .plane_rd, .plane_we, .plane_addr,
  .display_memory_address_lsb);
`default_nettype wire

// ===== verif/planar_graphics_write_read_datapath_bench.sv
// Purpose: Self-checking bench for pgwrd_datapath
// Assumes: Host side driven at falling edge
// Notes: Reference model mirrors plane contents
`include "pgwrd_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module planar_graphics_write_read_datapath_bench;
  logic mclk = 0, reset_n = 0, io_wr = 0, io_rd = 0, mem_wr = 0, mem_rd = 0;
  logic [15:0] io_addr = 0, plane_addr;
  logic [7:0] io_wdata = 0, mem_wdata = 0, io_rdata, mem_rdata, r [10];
  logic [19:0] mem_addr = 0;
  logic [31:0] plane_rdata, plane_wdata, sh [16], lat;
  logic [3:0] plane_we;
  logic io_rvalid, mem_rvalid, plane_rd, lsb, gmode, chain = 0, sload = 0;
  logic [31:0] sdata = 0, sout;
  logic [35:0] ioq [$], rq [$], wq [$];
  int n_errors = 0, n_compared = 0, cyc = 0;
  localparam logic [7:0] MSK [10] = '{15, 15, 15, 31, 3, 123, 15, 15, 255, 0};
  localparam logic [19:0] HIT [4] = '{'ha0003, 'ha0003, 'hb0003, 'hb8003};
  localparam logic [19:0] MISS [4] = '{'hc0003, 'hb0003, 'hb8003, 'hb0003};
  always #2.5 mclk = ~mclk;
  pgwrd_datapath i_pgwrd_datapath (.mclk, .reset_n, .io_wr, .io_rd, .io_addr,
    .io_wdata, .io_rdata, .io_rvalid, .mem_wr, .mem_rd, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_rvalid, .seq_chain4(chain), .seq_high_bit(1'b0),
    .plane_addr, .display_memory_address_lsb(lsb), .plane_rd, .plane_we,
    .plane_wdata, .plane_rdata, .shift_load(sload), .shift_data(sdata),
    .shift_out(sout), .graphics_mode(gmode));
  pgwrd_plane_model i_pgwrd_plane_model (.mclk, .plane_addr, .plane_rd,
    .plane_we, .plane_wdata, .plane_rdata);
  task automatic complete_run();
    if (ioq.size() + rq.size() + wq.size() != 0) begin
      n_errors++;
      $display("CHECK FAILED %0t answers missing", $time);
    end
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
    if (io_rvalid) chk(io_rdata, ioq.size() ? ioq.pop_front() : 'x);
    if (mem_rvalid) chk(mem_rdata, rq.size() ? rq.pop_front() : 'x);
    if (|plane_we) chk({plane_we, plane_wdata}, wq.size() ? wq.pop_front()
      : 'x);
  end
  function automatic logic [7:0] rot(logic [7:0] b, logic [2:0] n);
    return (b >> n) | (b << (4'd8 - n));
  endfunction
  function automatic logic [31:0] wexp(logic [7:0] h);
    logic [7:0] s, k, m, l;
    logic [31:0] o;
    m = r[5][1:0] == 3 ? rot(h, r[3][2:0]) & r[8] : r[8];
    for (int p = 0; p < 4; p++) begin
      l = lat[8*p +: 8];
      case (r[5][1:0])
        0: s = r[1][p] ? {8{r[0][p]}} : rot(h, r[3][2:0]);
        2: s = {8{h[p]}};
        default: s = {8{r[0][p]}};
      endcase
      case (r[3][4:3])
        1: k = s & l;
        2: k = s | l;
        3: k = s ^ l;
        default: k = s;
      endcase
      o[8*p +: 8] = (k & m) | (l & ~m);
    end
    return r[5][1:0] == 1 ? lat : o;
  endfunction
  function automatic logic [7:0] rexp(logic [31:0] d, logic a0);
    logic [7:0] c = 8'hff;
    logic [1:0] s;
    s = chain ? {r[4][1], a0} : r[4][1:0];
    for (int p = 0; p < 4; p++)
      if (r[7][p]) c &= ~(d[8*p +: 8] ^ {8{r[2][p]}});
    return r[5][3] ? c : d[8*s +: 8];
  endfunction
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    io_wr = w;
    io_rd = !w;
    io_addr = a;
    io_wdata = d;
    @(negedge mclk);
    io_wr = 0;
    io_rd = 0;
  endtask
  task automatic setr(input int i, input logic [7:0] v);
    io(1, `PGWRD_INDEX_PORT, 8'(i));
    io(1, `PGWRD_DATA_PORT, v);
    r[i] = v;
  endtask
  task automatic rdr(input int i, input logic [7:0] e);
    io(1, `PGWRD_INDEX_PORT, 8'(i));
    ioq.push_back(e);
    io(0, `PGWRD_DATA_PORT, 8'h00);
  endtask
  task automatic mem(input logic w, input logic [19:0] a, input logic [7:0] h,
      input logic hit);
    if (hit && w) begin
      sh[a[3:0]] = wexp(h);
      wq.push_back({4'hf, sh[a[3:0]]});
    end else if (hit) begin
      lat = sh[a[3:0]];
      rq.push_back(rexp(lat, a[0]));
    end
    @(negedge mclk);
    mem_wr = w;
    mem_rd = !w;
    mem_addr = a;
    mem_wdata = h;
    @(negedge mclk);
    mem_wr = 0;
    mem_rd = 0;
    repeat (2) @(negedge mclk);
  endtask
  initial begin
    logic [7:0] v;
    logic [31:0] e;
    void'($urandom(89402));
    for (int i = 0; i < 16; i++) sh[i] = (i + 1) * 32'h9e3779b9;
    repeat (20) @(negedge mclk);
    reset_n = 1;
    for (int i = 0; i < 10; i++) begin
      v = 8'($urandom) & MSK[i];
      rdr(i, i == 8 ? 8'hff : 8'h00);
      setr(i, v);
      rdr(i, v);
      ioq.push_back(i);
      io(0, `PGWRD_INDEX_PORT, 8'h00);
    end
    for (int j = 0; j < 4; j++) begin
      setr(5, j[1] ? 8'h40 : 8'h00);
      @(negedge mclk);
      sdata = $urandom;
      sload = 1;
      @(negedge mclk);
      sload = 0;
      e = sdata;
      if (j[1])
        for (int k = 0; k < 16; k++) e[2*(k ^ 3) +: 2] = sdata[2*k +: 2];
      chk(sout, e);
    end
    for (int w = 0; w < 4; w++) begin
      setr(6, 8'(w * 4 + w % 2));
      mem(0, HIT[w], 8'h00, 1);
      chk(gmode, w % 2);
      mem(0, MISS[w], 8'h00, 0);
      mem(1, MISS[w], 8'h00, 0);
    end
    setr(6, 8'h05);
    repeat (60) begin
      for (int i = 0; i < 8; i++)
        if (i != 6) setr(i, 8'($urandom) & (i == 5 ? 8'h0b : MSK[i]));
      v = 8'($urandom);
      chain = 1'($urandom);
      mem(0, {4'ha, v, 8'($urandom)}, 8'h00, 1);
      setr(8, 8'($urandom));
      mem(1, {4'ha, v, 8'($urandom)}, 8'($urandom), 1);
      mem(1, {4'ha, 16'($urandom)}, 8'($urandom), 1);
    end
    repeat (5) @(negedge mclk);
    complete_run();
  end
endmodule
`default_nettype wire
